// [logic/txdp_pkg.sv]
// Purpose: Shared constants and carrier types for transmit descriptor processing.
// Assumes: Little-endian host memory, 32-bit memory port carrying word-aligned byte addresses.
// Notes:   Register offsets are byte addresses on the Wishbone slave.
package txdp_pkg;
    // Wishbone register byte offsets.
    localparam logic [7:0] REG_CTRL  = 8'h00;
    localparam logic [7:0] REG_BASE  = 8'h04;
    localparam logic [7:0] REG_CUR   = 8'h08;
    localparam logic [7:0] REG_STAT  = 8'h0C;
    localparam logic [7:0] REG_CTL_W = 8'h10;
    localparam logic [7:0] REG_BUF_W = 8'h14;
    localparam logic [7:0] REG_NXT_W = 8'h18;
    // Control register bits.
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_POLL   = 1;
    localparam int CTRL_G_IP   = 2;
    localparam int CTRL_G_TCP  = 3;
    localparam int CTRL_G_UDP  = 4;
    localparam logic [31:0] CTRL_MASK = 32'h0000001D;
    // Descriptor words and bit fields.
    localparam logic [1:0] DW_STATUS = 2'h0;
    localparam logic [1:0] DW_NEXT   = 2'h3;
    localparam int OWN_BIT   = 31;
    localparam int IRQ_BIT   = 31;
    localparam int FIRST_BIT = 30;
    localparam int LAST_BIT  = 29;
    localparam int IPCK_BIT  = 28;
    localparam int TCPCK_BIT = 27;
    localparam int UDPCK_BIT = 26;
    localparam int WRAP_BIT  = 25;
    localparam int PORT_LO   = 20;
    localparam int PORT_W    = 2;
    localparam int LEN_W     = 11;
    localparam logic [31:0] STATUS_DONE = 32'h00000000;
    // Frame layout for checksum work.
    localparam logic [15:0] OFS_ETYPE_HI = 16'h000C;
    localparam logic [15:0] OFS_ETYPE_LO = 16'h000D;
    localparam logic [15:0] OFS_IP       = 16'h000E;
    localparam logic [15:0] OFS_TLEN_HI  = 16'h0010;
    localparam logic [15:0] OFS_TLEN_LO  = 16'h0011;
    localparam logic [15:0] OFS_PROTO    = 16'h0017;
    localparam logic [15:0] OFS_IPSUM    = 16'h0018;
    localparam logic [15:0] OFS_SRC      = 16'h001A;
    localparam logic [15:0] OFS_L4       = 16'h0022;
    localparam logic [15:0] OFS_UDPSUM   = 16'h0028;
    localparam logic [15:0] OFS_TCPSUM   = 16'h0032;
    localparam logic [15:0] IP_HDR_LEN   = 16'h0014;
    localparam logic [7:0]  ETYPE_HI     = 8'h08;
    localparam logic [7:0]  ETYPE_LO     = 8'h00;
    localparam logic [7:0]  VER_IHL      = 8'h45;
    localparam logic [7:0]  PROTO_TCP    = 8'h06;
    localparam logic [7:0]  PROTO_UDP    = 8'h11;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } txdp_mem_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
    } txdp_mem_rsp_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       first;
        logic       last;
    } txdp_byte_t;

    typedef struct packed {
        logic              valid;
        logic              irq;
        logic              ip_ok;
        logic [15:0]       ip_sum;
        logic              l4_ok;
        logic [15:0]       l4_sum;
        logic [15:0]       l4_ofs;
        logic [PORT_W-1:0] ports;
        logic              bcast;
        logic              lookup;
    } txdp_result_t;
endpackage

// [logic/txdp_engine.sv]
// Purpose: Walks the transmit descriptor ring, streams buffer bytes and works out checksums.
// Assumes: Memory port answers with ack in the same cycle or later; requests are held till ack.
// Notes:   Checksums are reported at frame end, the L4 one with its byte offset, for the FIFO to patch.
// How it works
// - A buffer flagged final segment closes the frame.
// - IP header checksum is computed when its flag asks and the frame is IPv4.
// - Only a 20-byte IP header is handled; other headers get no checksums.
// - Per-descriptor IP flag counts only while the global IP setting is clear.
// - TCP checksum is computed when asked; global TCP setting overrides the flag.
// - UDP checksum is computed when asked; global UDP setting overrides the flag.
// - Ring wrap flag sends the next fetch to the list base address.
// - A four-bit control field chooses the destination ports.
// - Lowest port-map bit is port 1, next bit is port 2.
// - Both port bits set means broadcast to every port.
// - A zero port map means use the internal lookup.
// - Port map is taken only from the final-segment descriptor.
// - The two upper port-map bits are ignored.
// - Exactly the buffer byte count is fetched from the buffer.
// - A zero byte count skips the buffer and moves to the next descriptor.
// - Buffer address may have any byte alignment.
// - Fourth descriptor word locates the following descriptor.
// - Ownership bit is cleared after each buffer is sent or when the buffer is empty.
// - Completion interrupt request is raised after the final segment when flagged.
// - A buffer flagged initial segment begins a new frame.
//
// The Wishbone register port and the register offsets were decided locally.
module txdp_engine #(
    parameter int WB_AW = 8
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [WB_AW-1:0]      wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    output txdp_pkg::txdp_mem_req_t    mem_o,
    input  wire txdp_pkg::txdp_mem_rsp_t mem_i,
    output txdp_pkg::txdp_byte_t       tx_o,
    input  wire logic                  tx_ready_i,
    output txdp_pkg::txdp_result_t     result_o
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_DESC, ST_DATA_RD, ST_DATA_OUT, ST_WRITEBACK
    } txdp_state_t;

    localparam int LEN_W_C  = txdp_pkg::LEN_W;
    localparam int PORT_W_C = txdp_pkg::PORT_W;

    txdp_state_t state;
    logic [31:0] ctrl;
    logic [31:0] base;
    logic [31:0] cur_desc;
    logic [31:0] w_status;
    logic [31:0] w_ctl;
    logic [31:0] w_buf;
    logic [31:0] w_next;
    logic [1:0]  widx;
    logic        kick;
    logic        suspended;
    logic [15:0] frames;
    logic [31:0] bptr;
    logic [LEN_W_C-1:0] remain;
    logic [31:0] data_word;
    logic [15:0] fpos;
    logic        in_frame;
    logic        f_ip;
    logic        f_tcp;
    logic        f_udp;
    logic        eth_ip;
    logic        std_hdr;
    logic [7:0]  proto;
    logic [15:0] tot_len;
    logic [31:0] ip_acc;
    logic [31:0] l4_acc;
    logic        frame_end;

    // A write lands on the edge where the master sees ack, while all it carries still stands.
    wire logic wb_req    = wb_cyc_i & wb_stb_i;
    wire logic wb_wr     = wb_req & wb_we_i & wb_ack_o;
    wire logic [7:0] adr = 8'(wb_adr_i);
    wire logic [31:0] sel_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                                  {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire logic byte_go   = (state == ST_DATA_OUT) & tx_ready_i;
    wire logic [7:0] cur_byte = data_word[{bptr[1:0], 3'b000} +: 8];

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [31:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction

    // Even frame offsets hold the high byte of each 16-bit word.
    function automatic logic [31:0] add_byte(input logic [31:0] acc, input logic [7:0] b,
                                             input logic odd);
        add_byte = acc + (odd ? {24'h000000, b} : {16'h0000, b, 8'h00});
    endfunction

    function automatic logic [15:0] fold(input logic [31:0] acc);
        logic [31:0] s;
        s = {16'h0000, acc[15:0]} + {16'h0000, acc[31:16]};
        s = {16'h0000, s[15:0]} + {16'h0000, s[31:16]};
        fold = ~s[15:0];
    endfunction

    // Wishbone slave: one wait state, ack drops the cycle after it was given.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req & ~wb_ack_o;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h00000000;
        end else if (wb_req & ~wb_ack_o) begin
            case (adr)
                txdp_pkg::REG_CTRL:  wb_dat_o <= ctrl;
                txdp_pkg::REG_BASE:  wb_dat_o <= base;
                txdp_pkg::REG_CUR:   wb_dat_o <= cur_desc;
                txdp_pkg::REG_STAT:  wb_dat_o <= {frames, 14'h0000, suspended,
                                                  state != ST_IDLE};
                txdp_pkg::REG_CTL_W: wb_dat_o <= w_ctl;
                txdp_pkg::REG_BUF_W: wb_dat_o <= w_buf;
                txdp_pkg::REG_NXT_W: wb_dat_o <= w_next;
                default:             wb_dat_o <= 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= 32'h00000000;
            base <= 32'h00000000;
        end else if (wb_wr) begin
            if (adr == txdp_pkg::REG_CTRL) begin
                ctrl <= merge(ctrl, wb_dat_i, sel_mask & txdp_pkg::CTRL_MASK);
            end
            if (adr == txdp_pkg::REG_BASE) begin
                base <= merge(base, wb_dat_i, sel_mask);
            end
        end
    end

    // A poll written in the cycle the engine starts is kept: set wins over clear.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            kick <= 1'b0;
        end else if (wb_wr & (adr == txdp_pkg::REG_CTRL) & wb_sel_i[0]
                     & wb_dat_i[txdp_pkg::CTRL_POLL]) begin
            kick <= 1'b1;
        end else if (state == ST_IDLE && ctrl[txdp_pkg::CTRL_ENABLE]) begin
            kick <= 1'b0;
        end
    end

    // Memory master: request held combinationally from state until ack.
    always_comb begin
        mem_o.req   = 1'b0;
        mem_o.we    = 1'b0;
        mem_o.addr  = 32'h00000000;
        mem_o.wdata = 32'h00000000;
        case (state)
            ST_DESC: begin
                mem_o.req  = 1'b1;
                mem_o.addr = cur_desc + {28'h0000000, widx, 2'b00};
            end
            ST_DATA_RD: begin
                mem_o.req  = 1'b1;
                mem_o.addr = {bptr[31:2], 2'b00};
            end
            ST_WRITEBACK: begin
                mem_o.req   = 1'b1;
                mem_o.we    = 1'b1;
                mem_o.addr  = cur_desc;
                mem_o.wdata = txdp_pkg::STATUS_DONE;
            end
            default: begin
                mem_o.req = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state     <= ST_IDLE;
            widx      <= 2'h0;
            cur_desc  <= 32'h00000000;
            w_status  <= 32'h00000000;
            w_ctl     <= 32'h00000000;
            w_buf     <= 32'h00000000;
            w_next    <= 32'h00000000;
            bptr      <= 32'h00000000;
            remain    <= '0;
            data_word <= 32'h00000000;
            suspended <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (wb_wr && adr == txdp_pkg::REG_BASE) begin
                        cur_desc <= merge(base, wb_dat_i, sel_mask);
                    end else if (ctrl[txdp_pkg::CTRL_ENABLE] && (kick || !suspended)) begin
                        state     <= ST_DESC;
                        widx      <= txdp_pkg::DW_STATUS;
                        suspended <= 1'b0;
                    end
                end
                ST_DESC: begin
                    if (mem_i.ack) begin
                        case (widx)
                            2'h0:    w_status <= mem_i.rdata;
                            2'h1:    w_ctl    <= mem_i.rdata;
                            2'h2:    w_buf    <= mem_i.rdata;
                            default: w_next   <= mem_i.rdata;
                        endcase
                        widx <= widx + 2'h1;
                        if (widx == txdp_pkg::DW_STATUS
                            && !mem_i.rdata[txdp_pkg::OWN_BIT]) begin
                            state     <= ST_IDLE;
                            suspended <= 1'b1;
                        end else if (widx == txdp_pkg::DW_NEXT) begin
                            bptr   <= w_buf;
                            remain <= w_ctl[LEN_W_C-1:0];
                            if (w_ctl[LEN_W_C-1:0] == '0) begin
                                state <= ST_WRITEBACK;
                            end else begin
                                state <= ST_DATA_RD;
                            end
                        end
                    end
                end
                ST_DATA_RD: begin
                    if (mem_i.ack) begin
                        data_word <= mem_i.rdata;
                        state     <= ST_DATA_OUT;
                    end
                end
                ST_DATA_OUT: begin
                    if (tx_ready_i) begin
                        bptr   <= bptr + 32'h00000001;
                        remain <= remain - 1'b1;
                        if (remain == LEN_W_C'(1)) begin
                            state <= ST_WRITEBACK;
                        end else if (bptr[1:0] == 2'b11) begin
                            state <= ST_DATA_RD;
                        end
                    end
                end
                ST_WRITEBACK: begin
                    if (mem_i.ack) begin
                        if (w_ctl[txdp_pkg::WRAP_BIT]) begin
                            cur_desc <= base;
                        end else begin
                            cur_desc <= w_next;
                        end
                        state <= ctrl[txdp_pkg::CTRL_ENABLE] ? ST_DESC : ST_IDLE;
                        widx  <= txdp_pkg::DW_STATUS;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Byte stream towards the MAC transmit FIFO.
    always_comb begin
        tx_o.valid = (state == ST_DATA_OUT);
        tx_o.data  = cur_byte;
        tx_o.first = (state == ST_DATA_OUT) && w_ctl[txdp_pkg::FIRST_BIT]
                     && (remain == w_ctl[LEN_W_C-1:0]);
        tx_o.last  = (state == ST_DATA_OUT) && w_ctl[txdp_pkg::LAST_BIT]
                     && (remain == LEN_W_C'(1));
    end

    assign frame_end = (state == ST_WRITEBACK) && mem_i.ack && w_ctl[txdp_pkg::LAST_BIT]
                       && in_frame;

    // Frame position and per-packet checksum requests; global settings win.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fpos     <= 16'h0000;
            in_frame <= 1'b0;
            f_ip     <= 1'b0;
            f_tcp    <= 1'b0;
            f_udp    <= 1'b0;
        end else if (byte_go && tx_o.first) begin
            fpos     <= 16'h0001;
            in_frame <= 1'b1;
            f_ip     <= ctrl[txdp_pkg::CTRL_G_IP]  | w_ctl[txdp_pkg::IPCK_BIT];
            f_tcp    <= ctrl[txdp_pkg::CTRL_G_TCP] | w_ctl[txdp_pkg::TCPCK_BIT];
            f_udp    <= ctrl[txdp_pkg::CTRL_G_UDP] | w_ctl[txdp_pkg::UDPCK_BIT];
        end else if (byte_go) begin
            fpos <= fpos + 16'h0001;
        end else if (frame_end) begin
            in_frame <= 1'b0;
        end
    end

    // Header parse; position 0 is the first byte of the frame.
    wire logic [15:0] bpos = tx_o.first ? 16'h0000 : fpos;
    wire logic odd = bpos[0];
    wire logic in_ip = (bpos >= txdp_pkg::OFS_IP) && (bpos < txdp_pkg::OFS_L4);
    wire logic ip_end_ok = (bpos < txdp_pkg::OFS_IP + tot_len) || (bpos < txdp_pkg::OFS_L4);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            eth_ip  <= 1'b0;
            std_hdr <= 1'b0;
            proto   <= 8'h00;
            tot_len <= 16'h0000;
        end else if (byte_go) begin
            case (bpos)
                txdp_pkg::OFS_ETYPE_HI: eth_ip  <= (cur_byte == txdp_pkg::ETYPE_HI);
                txdp_pkg::OFS_ETYPE_LO: eth_ip  <= eth_ip & (cur_byte == txdp_pkg::ETYPE_LO);
                txdp_pkg::OFS_IP:       std_hdr <= (cur_byte == txdp_pkg::VER_IHL);
                txdp_pkg::OFS_TLEN_HI:  tot_len <= {cur_byte, 8'h00};
                txdp_pkg::OFS_TLEN_LO:  tot_len <= {tot_len[15:8], cur_byte};
                txdp_pkg::OFS_PROTO:    proto   <= cur_byte;
                default:                proto   <= proto;
            endcase
            if (tx_o.first) begin
                eth_ip  <= 1'b0;
                std_hdr <= 1'b0;
            end
        end
    end

    // Running one's-complement sums; checksum fields count as zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ip_acc <= 32'h00000000;
            l4_acc <= 32'h00000000;
        end else if (byte_go) begin
            if (tx_o.first) begin
                ip_acc <= 32'h00000000;
                l4_acc <= 32'h00000000;
            end else begin
                if (in_ip && bpos != txdp_pkg::OFS_IPSUM
                    && bpos != txdp_pkg::OFS_IPSUM + 16'h0001) begin
                    ip_acc <= add_byte(ip_acc, cur_byte, odd);
                end
                if (bpos >= txdp_pkg::OFS_SRC && ip_end_ok
                    && !(proto == txdp_pkg::PROTO_TCP && (bpos == txdp_pkg::OFS_TCPSUM
                         || bpos == txdp_pkg::OFS_TCPSUM + 16'h0001))
                    && !(proto == txdp_pkg::PROTO_UDP && (bpos == txdp_pkg::OFS_UDPSUM
                         || bpos == txdp_pkg::OFS_UDPSUM + 16'h0001))) begin
                    l4_acc <= add_byte(l4_acc, cur_byte, odd);
                end
            end
        end
    end

    // Pseudo-header adds protocol and segment length at the end.
    wire logic [31:0] l4_total = l4_acc + {24'h000000, proto}
                                 + {16'h0000, tot_len - txdp_pkg::IP_HDR_LEN};
    wire logic [15:0] l4_raw = fold(l4_total);
    wire logic is_tcp = (proto == txdp_pkg::PROTO_TCP);
    wire logic is_udp = (proto == txdp_pkg::PROTO_UDP);
    wire logic ip_std = eth_ip & std_hdr;
    wire logic [PORT_W_C-1:0] pmap = w_ctl[txdp_pkg::PORT_LO +: PORT_W_C];

    // Frame summary, one-cycle pulse after the final status write-back.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result_o <= '0;
            frames   <= 16'h0000;
        end else begin
            result_o.valid <= frame_end;
            result_o.irq   <= frame_end & w_ctl[txdp_pkg::IRQ_BIT];
            if (frame_end) begin
                frames          <= frames + 16'h0001;
                result_o.ip_ok  <= f_ip & ip_std;
                result_o.ip_sum <= fold(ip_acc);
                result_o.l4_ok  <= ip_std & ((f_tcp & is_tcp) | (f_udp & is_udp));
                result_o.l4_sum <= (is_udp && l4_raw == 16'h0000) ? 16'hFFFF : l4_raw;
                result_o.l4_ofs <= is_tcp ? txdp_pkg::OFS_TCPSUM : txdp_pkg::OFS_UDPSUM;
                result_o.ports  <= pmap;
                result_o.bcast  <= &pmap;
                result_o.lookup <= ~|pmap;
            end
        end
    end
endmodule

// [sim/txdp_mem_model.sv]
// Purpose: Host memory behind the engine's bus-master port.
// Assumes: Word array indexed by address bits 9:2; the bench preloads it.
// Notes:   Answers after 0 to 3 idle cycles, so prompt and slow hosts both occur.
module txdp_mem_model (
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire txdp_pkg::txdp_mem_req_t req_i,
    output txdp_pkg::txdp_mem_rsp_t      rsp_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [256];
    logic [31:0] hold = 32'h0;
    logic        ack = 1'b0;
    int          wait_n = 0;
    int          seed = 25096;
    // Between answers the data lines carry the inverse, so a stale word never passes.
    assign rsp_o = '{ack, ack ? hold : ~hold};
    always @(posedge clk_i) begin
        ack <= 1'b0;
        if (rst_i) begin
            wait_n <= 0;
        end else if (req_i.req && !ack) begin
            if (wait_n > 0) begin
                wait_n <= wait_n - 1;
            end else begin
                ack <= 1'b1;
                hold <= mem[req_i.addr[9:2]];
                wait_n <= $random(seed) & 3;
                if (req_i.we) begin
                    mem[req_i.addr[9:2]] <= req_i.wdata;
                end
            end
        end
    end
endmodule

// [sim/txdp_engine_sva.sv]
// Purpose: Port-level checks for the descriptor engine.
// Assumes: One clock domain; bound to the engine from the bench.
// Notes:   The frame-end bound covers the memory model's slowest answer.
module txdp_engine_sva (
    input wire logic                    clk_i,
    input wire logic                    rst_i,
    input wire logic                    wb_cyc_i,
    input wire logic                    wb_stb_i,
    input wire logic                    wb_ack_o,
    input wire txdp_pkg::txdp_mem_req_t mem_o,
    input wire txdp_pkg::txdp_mem_rsp_t mem_i,
    input wire txdp_pkg::txdp_byte_t    tx_o,
    input wire logic                    tx_ready_i,
    input wire txdp_pkg::txdp_result_t  result_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("register answer late or long");
    mem_hold_a: assert property (mem_o.req && !mem_i.ack |=> mem_o.req && $stable(mem_o))
        else $error("memory request changed before answer");
    byte_hold_a: assert property (tx_o.valid && !tx_ready_i |=> tx_o.valid && $stable(tx_o))
        else $error("byte changed before it was taken");
    own_clear_a: assert property (mem_o.req && mem_o.we |-> !mem_o.wdata[31])
        else $error("write-back leaves ownership set");
    frame_done_a: assert property (tx_o.valid && tx_ready_i && tx_o.last
        |-> ##[1:60] result_o.valid)
        else $error("no result after final byte");
    bcast_map_a: assert property (result_o.valid |-> result_o.bcast == &result_o.ports)
        else $error("broadcast does not follow port map");
    lookup_map_a: assert property (result_o.valid |-> result_o.lookup == ~|result_o.ports)
        else $error("lookup does not follow port map");
    irq_frame_a: assert property (result_o.irq |-> result_o.valid)
        else $error("completion request outside frame end");
    cover property (result_o.valid && result_o.bcast);
    cover property (result_o.valid && result_o.lookup);
    cover property (result_o.valid && result_o.ip_ok);
endmodule

// [sim/txdp_engine_tb.sv]
// Purpose: Self-checking bench for the descriptor engine.
// Assumes: Descriptors at 0x100, 0x110, 0x120; buffers below 0x400.
// Notes:   Each round sends one 42-byte IPv4 frame over three descriptors.
module txdp_engine_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                    clk_i = 1'b0, rst_i = 1'b1, tx_ready_i = 1'b0;
    logic                    wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
    logic [7:0]              wb_adr_i = 8'h00;
    logic [3:0]              wb_sel_i = 4'hF;
    logic [31:0]             wb_dat_i = 32'h0, wb_dat_o, rd;
    txdp_pkg::txdp_mem_req_t mem_o;
    txdp_pkg::txdp_mem_rsp_t mem_i;
    txdp_pkg::txdp_byte_t    tx_o;
    txdp_pkg::txdp_result_t  result_o, res;
    int                      seed = 25096, errors = 0, tests_run = 0, cycles = 0, nres = 0;
    logic [9:0]              q [$];
    logic [7:0]              fr [42];
    logic [3:0]              map;
    logic                    ck;
    always #5 clk_i = ~clk_i;
    txdp_engine txdp_engine_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_o(mem_o),
        .mem_i(mem_i), .tx_o(tx_o), .tx_ready_i(tx_ready_i), .result_o(result_o));
    txdp_mem_model txdp_mem_model_i (.clk_i(clk_i), .rst_i(rst_i), .req_i(mem_o), .rsp_o(mem_i));
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        tx_ready_i <= 1'($random(seed));
        if (tx_o.valid && tx_ready_i) q.push_back({tx_o.first, tx_o.last, tx_o.data});
        if (result_o.valid) begin
            res <= result_o;
            nres <= nres + 1;
        end
        if (cycles == 30000) begin
            errors++;
            summarize();
        end
    end
    task automatic summarize();
        if (errors == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic desc(input int w, input logic [31:0] c, input logic [31:0] b, input logic [31:0] x);
        txdp_mem_model_i.mem[w + 1] = c;
        txdp_mem_model_i.mem[w + 2] = b;
        txdp_mem_model_i.mem[w + 3] = x;
        txdp_mem_model_i.mem[w] = 32'h80000000;
    endtask
    task automatic put(input logic [31:0] a, input int o, input int n);
        for (int i = 0; i < n; i++) txdp_mem_model_i.mem[(a + i) >> 2][8 * ((a + i) % 4) +: 8] = fr[o + i];
    endtask
    // One's-complement sum of frame bytes lo to hi-1 on top of a starting value.
    function automatic logic [15:0] sum16(input int lo, input int hi, input logic [31:0] s);
        for (int i = lo; i < hi; i += 2) s += {fr[i], fr[i + 1]};
        s = s[15:0] + s[31:16];
        s = s[15:0] + s[31:16];
        return ~s[15:0];
    endfunction
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b1, 8'h40, 32'hFFFFFFFF);
        wb(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0);
        wb(1'b0, txdp_pkg::REG_STAT, 32'h0);
        chk(rd, 32'h0);
        wb(1'b1, txdp_pkg::REG_BASE, 32'h100);
        for (int r = 0; r < 3; r++) begin
            for (int i = 0; i < 42; i++) fr[i] = 8'($random(seed));
            fr[12] = 8'h08; fr[13] = 8'h00; fr[14] = r == 2 ? 8'h46 : 8'h45;
            fr[16] = 8'h00; fr[17] = 8'h1C; fr[24] = 8'h00; fr[25] = 8'h00;
            fr[23] = txdp_pkg::PROTO_TCP;
            map = r == 0 ? 4'hF : r == 1 ? 4'h0 : 4'($random(seed));
            put(32'h201, 0, 20);
            put(32'h302, 20, 22);
            // The first descriptor is handed over last so the engine never races the setup.
            // Rounds 0 and 2 flag IP and TCP sums on every segment; round 1 leans on global IP.
            ck = r != 1;
            desc(72, {3'b101, ck, ck, 3'b010, map, 20'h00016}, 32'h302, 32'h0000ABC0);
            desc(68, {3'b000, ck, ck, 27'h0}, 32'h280, 32'h120);
            desc(64, {3'b010, ck, ck, 3'b000, ~map, 20'h00014}, 32'h201, 32'h110);
            q.delete();
            rd = 32'h0;
            wb(1'b1, txdp_pkg::REG_CTRL, {29'h0, r == 1, 2'b11});
            for (int n = 0; n < 200 && rd[1] !== 1'b1; n++) wb(1'b0, txdp_pkg::REG_STAT, 32'h0);
            chk(nres, r + 1);
            chk(q.size(), 42);
            foreach (q[i]) chk(q[i], {i == 0, i == 41, fr[i]});
            chk(res.ports, map[1:0]);
            chk(res.irq, 1'b1);
            chk(res.ip_ok, r != 2);
            if (r != 2) chk(res.ip_sum, sum16(14, 34, 32'h0));
            chk(res.l4_ok, r == 0);
            chk(res.l4_ofs, txdp_pkg::OFS_TCPSUM);
            // Pseudo-header adds protocol 6 and a segment length of 8 bytes.
            if (r == 0) chk(res.l4_sum, sum16(26, 42, 32'h0000000E));
            chk(res.bcast, map[1:0] == 2'h3);
            chk(res.lookup, map[1:0] == 2'h0);
            for (int w = 64; w < 76; w += 4) chk(txdp_mem_model_i.mem[w], 32'h0);
            wb(1'b0, txdp_pkg::REG_CUR, 32'h0);
            chk(rd, 32'h100);
        end
        summarize();
    end
endmodule
bind txdp_engine txdp_engine_sva txdp_engine_sva_i (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .mem_o(mem_o),
    .mem_i(mem_i), .tx_o(tx_o), .tx_ready_i(tx_ready_i), .result_o(result_o));
